// [core/tpc_timer.sv]
/*
  sixteen-bit timer with prescaler, modulo, coherent counter
  reads and NCH capture / compare / pwm channels.
  assumes: one clock mclk, synchronous active-low reset, a
  register master that holds strobes one cycle, pins and the
  fixed clock arrive asynchronously.
*/
// Strobed register access and the address map are this design's own decisions.
// Overview of operation
// R01: two-bit field picks off, bus, fixed, external
// R02: external clock at most quarter bus rate
// R03: prescaler divides by two to the code
// R04: counter byte read freezes both bytes
// R05: reset, counter write, control write release buffer
// R06: reset zeroes the counter
// R07: background mode freezes counter and buffer
// R08: at modulo wrap or reverse, set overflow
// R09: half-written modulo suppresses overflow flag
// R10: zero modulo means free running counter
// R11: software rewrites modulo early after overflow
// R12: flag on capture edge or compare match
// R13: center pwm flags every match
// R14: interrupt when flag and enable both set
// R15: clear by read then write zero
// R16: new event restarts the clear sequence
// R17: reset clears flag and enable
// R18: mode high bit selects edge pwm
// R19: mode low bit picks capture or compare
// R20: edge field sets edge, action, polarity
// R21: edge field zero releases the pin
// R22: software frees pin used as clock
// R23: capture edges and compare pin actions
// R24: pwm polarity from edge field
// R25: external and fixed clocks synchronised first
// R26: center select makes up/down counter
// R27: counter steps once per prescaler pulse
`default_nettype none
`include "tpc_params.svh"
module tpc_timer #(
  parameter int NCH = 2
) (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire tpc_pkg::tpc_bus_t bus,
  output logic [7:0]             rdData,
  input  wire logic              bgndMode,
  input  wire logic              fixedClk,
  input  wire logic              extClkPin,
  input  wire logic [NCH-1:0]    chPinIn,
  output logic [NCH-1:0]         chPinOut,
  output logic [NCH-1:0]         chPinOe,
  output logic [NCH-1:0]         chIrq,
  output logic                   ovfIrq
);
  import tpc_pkg::*;

  localparam int NIN = NCH + 2;  // fixed, external, pins

  // channel register decode
  function automatic logic chHit(
    input logic [7:0] a,
    input int         n,
    input logic [7:0] s
  );
    chHit = (a == 8'(`TPC_A_CHBASE + `TPC_A_CHSTEP * n + s));
  endfunction : chHit

  // prescaler compare mask
  function automatic logic [6:0] psMask(input logic [2:0] ps);
    psMask = 7'((8'h01 << ps) - 8'h01);
  endfunction : psMask

  // channel mode from control bits
  function automatic tpc_mode_t modeOf(
    input logic ctr,
    input logic msh,
    input logic msl
  );
    if (ctr)
      modeOf = CM_CPWM;
    else if (msh)
      modeOf = CM_EPWM;
    else if (msl)
      modeOf = CM_CMP;
    else
      modeOf = CM_CAPT;
  endfunction : modeOf

  // input synchronisers
  logic [NIN-1:0] pinRaw;        // fixed, external, channels
  logic [2:0]     syn_q [NIN];   // three-stage shift
  logic [NIN-1:0] pinLvl_q;      // agreed level
  logic [NIN-1:0] pinPrev_q;     // level one cycle back
  logic [NIN-1:0] pinRise;       // rising edge
  logic [NIN-1:0] pinFall;       // falling edge

  // module control and status
  logic           ovfFlag_q;     // overflow flag
  logic           ovfArm_q;      // flag seen set by a read
  logic           ovfIe_q;       // overflow irq enable
  logic           ctr_q;         // center aligned select
  logic [1:0]     clks_q;        // clock source select
  logic [2:0]     ps_q;          // prescale select
  logic [6:0]     psCnt_q;       // prescaler count

  // counter, modulo, read buffer
  logic [15:0]    cnt_q;         // main counter
  logic           down_q;        // counting down
  logic [15:0]    mod_q;         // modulo value
  logic           modHSeen_q;    // high byte waits for low
  logic           modLSeen_q;    // low byte waits for high
  logic [15:0]    cntBuf_q;      // frozen counter copy
  logic           cntLat_q;      // buffer latched
  logic           firstHi_q;     // first read was high

  // channels
  logic [NCH-1:0] chFlag_q;      // event flags
  logic [NCH-1:0] chArm_q;       // clear sequence armed
  logic [NCH-1:0] chIe_q;        // irq enables
  logic [NCH-1:0] chMsh_q;       // mode select high
  logic [NCH-1:0] chMsl_q;       // mode select low
  logic [1:0]     chEls_q [NCH]; // edge / level select
  logic [15:0]    chVal_q [NCH]; // channel value
  logic [15:0]    chBuf_q [NCH]; // value write buffer
  logic [NCH-1:0] chVhSeen_q;    // high byte buffered
  logic [NCH-1:0] chVlSeen_q;    // low byte buffered
  tpc_mode_t      chMode [NCH];  // decoded mode
  logic [NCH-1:0] chMatch;       // compare match this tick
  logic [NCH-1:0] chEvt;         // flag set event

  // outputs
  logic [7:0]     rdData_q;
  logic [7:0]     rdMux;
  logic [NCH-1:0] chPinOut_q;
  logic [NCH-1:0] chPinOe_q;
  logic [NCH-1:0] chIrq_q;
  logic           ovfIrq_q;

  // decoded strobes and ticks
  logic           mscWr;
  logic           mscRd;
  logic           cntWr;
  logic           cntRd;
  logic           srcTick;
  logic           psTick;
  logic           cntTick;
  logic [15:0]    term;
  logic           atTerm;
  logic           modPend;
  logic           ovfSet;
  logic           wrapTick;

  assign mscWr = bus.wr && (bus.addr == `TPC_A_MSC);
  assign mscRd = bus.rd && (bus.addr == `TPC_A_MSC);
  assign cntWr = bus.wr && ((bus.addr == `TPC_A_CNTH) ||
                            (bus.addr == `TPC_A_CNTL));
  assign cntRd = bus.rd && ((bus.addr == `TPC_A_CNTH) ||
                            (bus.addr == `TPC_A_CNTL));

  // pins pass three flops, level taken when stages 2 and 3 agree
  assign pinRaw = {chPinIn, extClkPin, fixedClk};
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < NIN; i++)
    begin
      if (!reset_n)
      begin
        syn_q[i]     <= 3'h0;
        pinLvl_q[i]  <= 1'b0;
        pinPrev_q[i] <= 1'b0;
      end
      else
      begin
        syn_q[i]     <= {syn_q[i][1:0], pinRaw[i]};  // see R25
        if (syn_q[i][1] == syn_q[i][2])
          pinLvl_q[i] <= syn_q[i][2];
        pinPrev_q[i] <= pinLvl_q[i];
      end
    end
  end
  assign pinRise = pinLvl_q & ~pinPrev_q;
  assign pinFall = ~pinLvl_q & pinPrev_q;

  // clock source select, edges of slow sources count once
  always_comb
  begin
    case (clks_q)  // see R01
      `TPC_CK_BUS: srcTick = 1'b1;
      `TPC_CK_FIX: srcTick = pinRise[0];
      `TPC_CK_EXT: srcTick = pinRise[1];  // see R02
      default:     srcTick = 1'b0;
    endcase
  end

  // prescaler, pulse when masked low bits are all ones
  assign psTick  = srcTick && !bgndMode &&
                   ((psCnt_q & psMask(ps_q)) == psMask(ps_q));  // see R03
  assign cntTick = psTick;  // see R27
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      psCnt_q <= 7'h00;
    else if (srcTick && !bgndMode)
      psCnt_q <= psCnt_q + 7'h01;
  end

  // terminal count, zero modulo runs full range
  assign term    = (mod_q == `TPC_RST_W) ? `TPC_TERM_MAX : mod_q;  // see R10
  assign atTerm  = (cnt_q == term);
  assign modPend = modHSeen_q || modLSeen_q;
  assign ovfSet  = cntTick && !cntWr && atTerm && !down_q &&
                   !modPend;  // see R08 see R09
  assign wrapTick = cntTick && atTerm && !ctr_q;

  // main counter, up or up/down
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      cnt_q  <= `TPC_RST_W;  // see R06
      down_q <= 1'b0;
    end
    else if (cntWr)
    begin
      cnt_q  <= `TPC_RST_W;
      down_q <= 1'b0;
    end
    else if (cntTick)
    begin
      if (!ctr_q)
      begin
        down_q <= 1'b0;
        cnt_q  <= atTerm ? `TPC_RST_W : cnt_q + 16'h0001;  // see R08
      end
      else if (!down_q)
      begin
        // up leg, turn at the terminal count
        down_q <= atTerm;  // see R26
        cnt_q  <= atTerm ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
      end
      else
      begin
        // down leg, turn at zero
        down_q <= (cnt_q != `TPC_RST_W);
        cnt_q  <= (cnt_q == `TPC_RST_W) ? cnt_q + 16'h0001
                                         : cnt_q - 16'h0001;
      end
    end
  end

  // modulo bytes load at once, pending flag held until both halves written
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      mod_q      <= `TPC_RST_W;  // see R10
      modHSeen_q <= 1'b0;
      modLSeen_q <= 1'b0;
    end
    else if (bus.wr && (bus.addr == `TPC_A_MODH))
    begin
      mod_q[15:8] <= bus.wdata;
      modHSeen_q  <= !modLSeen_q;  // see R09
      modLSeen_q  <= 1'b0;
    end
    else if (bus.wr && (bus.addr == `TPC_A_MODL))
    begin
      mod_q[7:0] <= bus.wdata;
      modLSeen_q <= !modHSeen_q;
      modHSeen_q <= 1'b0;
    end
  end

  // coherent counter read buffer
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      cntLat_q  <= 1'b0;  // see R05
      firstHi_q <= 1'b0;
      cntBuf_q  <= `TPC_RST_W;
    end
    else if (cntWr || mscWr)
      cntLat_q <= 1'b0;  // see R05
    else if (cntRd && !bgndMode)  // see R07
    begin
      if (!cntLat_q)
      begin
        cntLat_q  <= 1'b1;  // see R04
        cntBuf_q  <= cnt_q;
        firstHi_q <= (bus.addr == `TPC_A_CNTH);
      end
      else if ((bus.addr == `TPC_A_CNTH) != firstHi_q)
        cntLat_q <= 1'b0;
    end
  end

  // module control, overflow flag with read-then-write clear
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      ovfFlag_q <= 1'b0;
      ovfArm_q  <= 1'b0;
      ovfIe_q   <= 1'b0;
      ctr_q     <= 1'b0;
      clks_q    <= `TPC_CK_OFF;
      ps_q      <= 3'h0;
    end
    else
    begin
      if (mscWr)
      begin
        ovfIe_q <= bus.wdata[`TPC_B_IE];
        ctr_q   <= bus.wdata[`TPC_B_CTR];
        clks_q  <= bus.wdata[`TPC_B_CLKS];
        ps_q    <= bus.wdata[`TPC_B_PS];
      end
      if (ovfSet)
      begin
        ovfFlag_q <= 1'b1;  // set wins over clear
        ovfArm_q  <= 1'b0;
      end
      else if (mscWr)
      begin
        if (ovfArm_q && !bus.wdata[`TPC_B_FLAG])
          ovfFlag_q <= 1'b0;
        ovfArm_q <= 1'b0;
      end
      else if (mscRd && ovfFlag_q)
        ovfArm_q <= 1'b1;
    end
  end

  // channel mode, match and event decode
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      chMode[i]  = modeOf(ctr_q, chMsh_q[i], chMsl_q[i]);  // see R18 see R19
      chMatch[i] = cntTick && (cnt_q == chVal_q[i]);
      if (chMode[i] == CM_CAPT)
      begin
        case (chEls_q[i])  // see R23
          `TPC_ELS_RISE: chEvt[i] = pinRise[i+2];
          `TPC_ELS_FALL: chEvt[i] = pinFall[i+2];
          `TPC_ELS_BOTH: chEvt[i] = pinRise[i+2] || pinFall[i+2];
          default:       chEvt[i] = 1'b0;
        endcase
      end
      else
        chEvt[i] = chMatch[i];  // see R12 see R13
    end
  end

  // channel control and flag clear sequence
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < NCH; i++)
    begin
      if (!reset_n)
      begin
        chFlag_q[i] <= 1'b0;  // see R17
        chArm_q[i]  <= 1'b0;
        chIe_q[i]   <= 1'b0;
        chMsh_q[i]  <= 1'b0;
        chMsl_q[i]  <= 1'b0;
        chEls_q[i]  <= `TPC_ELS_OFF;
      end
      else
      begin
        if (bus.wr && chHit(bus.addr, i, `TPC_S_SC))
        begin
          chIe_q[i]  <= bus.wdata[`TPC_B_IE];
          chMsh_q[i] <= bus.wdata[`TPC_B_MSH];
          chMsl_q[i] <= bus.wdata[`TPC_B_MSL];
          chEls_q[i] <= bus.wdata[`TPC_B_ELS];  // see R20
        end
        if (chEvt[i])
        begin
          chFlag_q[i] <= 1'b1;  // see R12
          chArm_q[i]  <= 1'b0;  // see R16
        end
        else if (bus.wr && chHit(bus.addr, i, `TPC_S_SC))
        begin
          if (chArm_q[i] && !bus.wdata[`TPC_B_FLAG])
            chFlag_q[i] <= 1'b0;  // see R15
          chArm_q[i] <= 1'b0;
        end
        else if (bus.rd && chHit(bus.addr, i, `TPC_S_SC) && chFlag_q[i])
          chArm_q[i] <= 1'b1;  // see R15
      end
    end
  end

  // channel value, capture load and buffered writes
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < NCH; i++)
    begin
      if (!reset_n)
      begin
        chVal_q[i]    <= `TPC_RST_W;
        chBuf_q[i]    <= `TPC_RST_W;
        chVhSeen_q[i] <= 1'b0;
        chVlSeen_q[i] <= 1'b0;
      end
      else
      begin
        if (chEvt[i] && (chMode[i] == CM_CAPT))
          chVal_q[i] <= cnt_q;
        if (bus.wr && chHit(bus.addr, i, `TPC_S_SC))
        begin
          chVhSeen_q[i] <= 1'b0;
          chVlSeen_q[i] <= 1'b0;
        end
        else if (bus.wr && chHit(bus.addr, i, `TPC_S_VH))
        begin
          chBuf_q[i][15:8] <= bus.wdata;
          if (chVlSeen_q[i])
            chVal_q[i] <= {bus.wdata, chBuf_q[i][7:0]};
          chVhSeen_q[i] <= !chVlSeen_q[i];
          chVlSeen_q[i] <= 1'b0;
        end
        else if (bus.wr && chHit(bus.addr, i, `TPC_S_VL))
        begin
          chBuf_q[i][7:0] <= bus.wdata;
          if (chVhSeen_q[i])
            chVal_q[i] <= {chBuf_q[i][15:8], bus.wdata};
          chVlSeen_q[i] <= !chVhSeen_q[i];
          chVhSeen_q[i] <= 1'b0;
        end
      end
    end
  end

  // channel pin drive per mode
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < NCH; i++)
    begin
      if (!reset_n)
      begin
        chPinOut_q[i] <= 1'b0;
        chPinOe_q[i]  <= 1'b0;
      end
      else
      begin
        chPinOe_q[i] <= (chEls_q[i] != `TPC_ELS_OFF) &&
                        (chMode[i] != CM_CAPT);  // see R21
        case (chMode[i])
          CM_CMP:
          begin
            // toggle, clear or set on match
            if (chMatch[i])
            begin
              case (chEls_q[i])  // see R23
                `TPC_ELS_RISE: chPinOut_q[i] <= !chPinOut_q[i];
                `TPC_ELS_FALL: chPinOut_q[i] <= 1'b0;
                `TPC_ELS_BOTH: chPinOut_q[i] <= 1'b1;
                default:       chPinOut_q[i] <= chPinOut_q[i];
              endcase
            end
          end
          CM_EPWM:
          begin
            // match ends the pulse, wrap starts it
            if (chMatch[i])
              chPinOut_q[i] <= chEls_q[i][0];  // see R24
            else if (wrapTick)
              chPinOut_q[i] <= !chEls_q[i][0];
          end
          CM_CPWM:
          begin
            // up match ends, down match starts
            if (chMatch[i])
              chPinOut_q[i] <= down_q ? !chEls_q[i][0]
                                      : chEls_q[i][0];  // see R24
          end
          default:
          begin
            chPinOut_q[i] <= chPinOut_q[i];
          end
        endcase
      end
    end
  end

  // interrupt requests
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      chIrq_q  <= '0;
      ovfIrq_q <= 1'b0;
    end
    else
    begin
      chIrq_q  <= chFlag_q & chIe_q;  // see R14
      ovfIrq_q <= ovfFlag_q && ovfIe_q;
    end
  end

  // read mux, unmapped reads as zero
  always_comb
  begin
    rdMux = `TPC_RST_B;
    if (bus.addr == `TPC_A_MSC)
      rdMux = {ovfFlag_q, ovfIe_q, ctr_q, clks_q, ps_q};
    else if (bus.addr == `TPC_A_CNTH)
      rdMux = cntLat_q ? cntBuf_q[15:8] : cnt_q[15:8];
    else if (bus.addr == `TPC_A_CNTL)
      rdMux = cntLat_q ? cntBuf_q[7:0] : cnt_q[7:0];
    else if (bus.addr == `TPC_A_MODH)
      rdMux = mod_q[15:8];
    else if (bus.addr == `TPC_A_MODL)
      rdMux = mod_q[7:0];
    for (int i = 0; i < NCH; i++)
    begin
      if (chHit(bus.addr, i, `TPC_S_SC))
        rdMux = {chFlag_q[i], chIe_q[i], chMsh_q[i], chMsl_q[i],
                 chEls_q[i], 2'h0};
      else if (chHit(bus.addr, i, `TPC_S_VH))
        rdMux = chVal_q[i][15:8];
      else if (chHit(bus.addr, i, `TPC_S_VL))
        rdMux = chVal_q[i][7:0];
    end
  end

  // read data stands one cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      rdData_q <= `TPC_RST_B;
    else
      rdData_q <= bus.rd ? rdMux : `TPC_RST_B;
  end

  assign rdData   = rdData_q;
  assign chPinOut = chPinOut_q;
  assign chPinOe  = chPinOe_q;
  assign chIrq    = chIrq_q;
  assign ovfIrq   = ovfIrq_q;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence chRead0;
    bus.rd && chHit(bus.addr, 0, `TPC_S_SC) && chFlag_q[0] && !chEvt[0];
  endsequence
  sequence chClear0;
    bus.wr && chHit(bus.addr, 0, `TPC_S_SC) && !bus.wdata[7] && !chEvt[0];
  endsequence

  clock_off_a: assert property ((clks_q == `TPC_CK_OFF) |-> !cntTick)  // see R01
    else $error("counter ticks with no clock source");
  prescale_two_a: assert property ((psTick && ps_q == 3'h1 &&  // see R03
      clks_q == `TPC_CK_BUS && !bgndMode && !mscWr) ##1 (!bgndMode && !mscWr)
      |-> !psTick ##1 (psTick || bgndMode))
    else $error("divide by two prescale wrong");
  latch_take_a: assert property ((cntRd && !cntLat_q && !bgndMode)  // see R04
      |=> cntLat_q && cntBuf_q == $past(cnt_q))
    else $error("counter read did not latch");
  latch_free_a: assert property ((mscWr || cntWr) |=> !cntLat_q)  // see R05
    else $error("read buffer not released");
  reset_zero_a: assert property (@(posedge mclk) disable iff (1'b0) !reset_n |=>  // see R06
      cnt_q == 16'h0000 && !chFlag_q[0] && !chIe_q[0])
    else $error("reset left counter or channel state");
  bgnd_hold_a: assert property (bgndMode && !cntWr && !mscWr  // see R07
      |=> $stable(cnt_q) && $stable(cntLat_q))
    else $error("counter moved in background mode");
  up_wrap_a: assert property ((cntTick && !ctr_q && atTerm && !cntWr)  // see R08
      |=> cnt_q == 16'h0000)
    else $error("counter did not wrap at terminal count");
  mod_hold_a: assert property (modPend |=> !$rose(ovfFlag_q))  // see R09
    else $error("overflow set while modulo half written");
  ch_irq_a: assert property ((chFlag_q[0] && chIe_q[0]) |=> chIrq_q[0])  // see R14
    else $error("channel irq missing");
  ch_clear_a: assert property (chRead0 ##1 (!chEvt[0] && !bus.wr)[*1]  // see R15
      ##1 chClear0 |=> !chFlag_q[0])
    else $error("channel flag clear sequence failed");
  ch_set_wins_a: assert property (chEvt[0] |=> chFlag_q[0] && !chArm_q[0])  // see R16
    else $error("channel event lost");
  pin_free_a: assert property ((chEls_q[0] == 2'h0) |=> !chPinOe_q[0])  // see R21
    else $error("pin driven with edge field zero");
endmodule : tpc_timer
`default_nettype wire

// [core/tpc_params.svh]
/*
  constants for the timer pwm core: register indices, field
  positions, reset values and selector codes.
  assumes: included by bare name, once per compilation unit.
*/
`ifndef TPC_PARAMS_SVH
`define TPC_PARAMS_SVH
// register indices on the plain register port
`define TPC_A_MSC    8'h00
`define TPC_A_CNTH   8'h01
`define TPC_A_CNTL   8'h02
`define TPC_A_MODH   8'h03
`define TPC_A_MODL   8'h04
`define TPC_A_CHBASE 8'h08
`define TPC_A_CHSTEP 8'h04
// offsets inside one channel block
`define TPC_S_SC     8'h00
`define TPC_S_VH     8'h01
`define TPC_S_VL     8'h02
// field positions
`define TPC_B_FLAG   7
`define TPC_B_IE     6
`define TPC_B_CTR    5
`define TPC_B_MSH    5
`define TPC_B_MSL    4
`define TPC_B_CLKS   4:3
`define TPC_B_PS     2:0
`define TPC_B_ELS    3:2
// clock source codes
`define TPC_CK_OFF   2'h0
`define TPC_CK_BUS   2'h1
`define TPC_CK_FIX   2'h2
`define TPC_CK_EXT   2'h3
// edge / level codes
`define TPC_ELS_OFF  2'h0
`define TPC_ELS_RISE 2'h1
`define TPC_ELS_FALL 2'h2
`define TPC_ELS_BOTH 2'h3
// reset values and terminal count
`define TPC_RST_B    8'h00
`define TPC_RST_W    16'h0000
`define TPC_TERM_MAX 16'hffff
`endif

// [core/tpc_pkg.sv]
/*
  types for the timer pwm core: register port carrier and the
  channel mode code.
  assumes: tpc_params.svh sits on the include path.
*/
`default_nettype none
`include "tpc_params.svh"
package tpc_pkg;
  // one register port access
  typedef struct packed {
    logic [7:0] addr;   // register index
    logic [7:0] wdata;  // write data
    logic       wr;     // write strobe
    logic       rd;     // read strobe
  } tpc_bus_t;
  // channel operating mode, one-hot
  typedef enum logic [3:0] {
    CM_CAPT = 4'b0001,
    CM_CMP  = 4'b0010,
    CM_EPWM = 4'b0100,
    CM_CPWM = 4'b1000
  } tpc_mode_t;
endpackage : tpc_pkg
`default_nettype wire

// [tb/tpc_far_model.sv]
/* far side of the timer: fixed and external clock sources, channel pin wires.
   assumes: clocked by the bench clock mclk. */
`default_nettype none
module tpc_far_model #(
  parameter int NCH = 2
) (
  input  wire logic           mclk,
  input  wire logic [NCH-1:0] pinDrv,
  input  wire logic [NCH-1:0] chPinOut,
  input  wire logic [NCH-1:0] chPinOe,
  output logic                fixedClk,
  output logic                extClkPin,
  output logic [NCH-1:0]      chPinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div_q = 3'h0; // free-running source divider
  // divider behind both clock sources
  always @(posedge mclk) div_q <= div_q + 3'h1;
  assign fixedClk  = div_q[2]; // an eighth of mclk
  assign extClkPin = div_q[1]; // a quarter of mclk
  // wire level: the timer wins while it drives
  assign chPinIn = (chPinOe & chPinOut) | (~chPinOe & pinDrv);
endmodule : tpc_far_model
`default_nettype wire

// [tb/timer_pwm_counter_channels_tb.sv]
/* bench for the timer core: register tasks, counter, modulo, channel checks.
   assumes: package and design compiled first. */
`default_nettype none
`include "tpc_params.svh"
module timer_pwm_counter_channels_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tpc_pkg::*;
  logic        mclk = 1'b0, reset_n = 1'b0, bgndMode = 1'b0, ex;
  tpc_bus_t    bus = '0;
  logic [7:0]  rdData, d, a8, c8;
  logic [1:0]  pinDrv = 2'h0, chPinOut, chPinOe, chPinIn, chIrq;
  logic        fixedClk, extClkPin, ovfIrq;
  logic [15:0] v1, v2;
  int          num_errors = 0, n_tests = 0, h1, h2, h3;
  logic [7:0]  mscTab [11] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f,
                              8'h10, 8'h18, 8'h00};
  logic [15:0] stepTab [11] = '{16'h0200, 16'h0100, 16'h0080, 16'h0040, 16'h0020,
                               16'h0010, 16'h0008, 16'h0004, 16'h0040, 16'h0080, 16'h0000};
  // bench clock, 10 ns
  always #5 mclk = ~mclk;
  tpc_timer #(.NCH(2)) dut (.mclk(mclk), .reset_n(reset_n), .bus(bus), .rdData(rdData),
    .bgndMode(bgndMode), .fixedClk(fixedClk), .extClkPin(extClkPin), .chPinIn(chPinIn),
    .chPinOut(chPinOut), .chPinOe(chPinOe), .chIrq(chIrq), .ovfIrq(ovfIrq));
  tpc_far_model #(.NCH(2)) far (.mclk(mclk), .pinDrv(pinDrv), .chPinOut(chPinOut),
    .chPinOe(chPinOe), .fixedClk(fixedClk), .extClkPin(extClkPin), .chPinIn(chPinIn));
  // compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge mclk);
    bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask : wr
  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 r = rdData;
  endtask : rd
  task automatic rc(input string what, input logic [7:0] a, input logic [7:0] e);
    rd(a, d);
    chk(what, {8'h00, d}, {8'h00, e});
  endtask : rc
  // counter read in two bytes, 300 cycles apart; value is that of the first read
  task automatic snap(input logic hiFirst, output logic [15:0] v);
    logic [7:0] b0, b1;
    rd(hiFirst ? `TPC_A_CNTH : `TPC_A_CNTL, b0);
    repeat (300) @(posedge mclk);
    rd(hiFirst ? `TPC_A_CNTL : `TPC_A_CNTH, b1);
    v = hiFirst ? {b0, b1} : {b1, b0};
  endtask : snap
  // program channel 0, then count high cycles of its pin over 480 cycles
  task automatic pwmHi(input logic [7:0] sc, input logic [7:0] v, output int n);
    wr(`TPC_A_CHBASE + `TPC_S_VH, 8'h00);
    wr(`TPC_A_CHBASE + `TPC_S_VL, v);
    wr(`TPC_A_CHBASE, sc);
    repeat (64) @(posedge mclk);
    n = 0;
    repeat (480)
    begin
      @(posedge mclk);
      #1 n += int'(chPinOut[0]);
    end
  endtask : pwmHi
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // main sequence
  initial
  begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    rc("msc", `TPC_A_MSC, 8'h00);
    rc("modh", `TPC_A_MODH, 8'h00);
    rc("modl", `TPC_A_MODL, 8'h00);
    rc("cnth", `TPC_A_CNTH, 8'h00);
    rc("cntl", `TPC_A_CNTL, 8'h00);
    rc("chsc", `TPC_A_CHBASE, 8'h00);
    rc("unmapped", 8'h07, 8'h00);
    // sources and divisors; channel pin stays detached
    for (int i = 0; i < 11; i++)
    begin
      wr(`TPC_A_MSC, mscTab[i]);
      repeat (16) @(posedge mclk);
      snap(1'b1, v1);
      repeat (208) @(posedge mclk);
      snap(1'b0, v2);
      chk("step", v2 - v1, stepTab[i]);
    end
    // control write must drop a pending latch
    wr(`TPC_A_MSC, 8'h08);
    rd(`TPC_A_CNTH, d);
    repeat (300) @(posedge mclk);
    wr(`TPC_A_MSC, 8'h00);
    rd(`TPC_A_CNTL, a8);
    rd(`TPC_A_CNTH, d);
    rd(`TPC_A_CNTL, c8);
    chk("release", {8'h00, a8}, {8'h00, c8});
    // background freeze
    wr(`TPC_A_MSC, 8'h08);
    bgndMode <= 1'b1;
    repeat (4) @(posedge mclk);
    snap(1'b1, v1);
    snap(1'b0, v2);
    chk("bgnd", v2, v1);
    @(posedge mclk);
    bgndMode <= 1'b0;
    // modulo 15, counter zeroed first
    wr(`TPC_A_MSC, 8'h00);
    wr(`TPC_A_CNTH, 8'h00);
    wr(`TPC_A_MODH, 8'h00);
    wr(`TPC_A_MODL, 8'h0f);
    wr(`TPC_A_MSC, 8'h08);
    snap(1'b1, v1);
    chk("wrap", {15'h0, v1 <= 16'h000f}, 16'h0001);
    rc("ovf", `TPC_A_MSC, 8'h88);
    wr(`TPC_A_MODH, 8'h00);
    wr(`TPC_A_MSC, 8'h08);
    repeat (100) @(posedge mclk);
    rc("ovf half", `TPC_A_MSC, 8'h08);
    wr(`TPC_A_MODL, 8'h0f);
    repeat (40) @(posedge mclk);
    rc("ovf back", `TPC_A_MSC, 8'h88);
    wr(`TPC_A_MSC, 8'hc8);
    repeat (3) @(posedge mclk);
    #1 chk("ovfirq", {15'h0, ovfIrq}, 16'h0001);
    // capture edges per edge code, rise then fall
    for (int e = 1; e < 4; e++)
      for (int r = 0; r < 2; r++)
      begin
        rd(`TPC_A_CHBASE, d);
        wr(`TPC_A_CHBASE, {4'h4, e[1:0], 2'h0});
        repeat (4) @(posedge mclk);
        pinDrv[0] <= ~pinDrv[0];
        repeat (10) @(posedge mclk);
        ex = (e == 3) || (e == r + 1);
        rc("cap", `TPC_A_CHBASE, {ex, 3'h4, e[1:0], 2'h0});
        chk("chirq", {14'h0, chIrq}, {15'h0, ex});
        chk("cap oe", {14'h0, chPinOe}, 16'h0000);
      end
    // event between arming read and clearing write keeps the flag
    rd(`TPC_A_CHBASE, d);
    @(posedge mclk);
    pinDrv[0] <= ~pinDrv[0];
    repeat (10) @(posedge mclk);
    wr(`TPC_A_CHBASE, 8'h4c);
    rc("race", `TPC_A_CHBASE, 8'hcc);
    rd(`TPC_A_CHBASE, d);
    wr(`TPC_A_CHBASE, 8'hcc);
    rc("wr one", `TPC_A_CHBASE, 8'hcc);
    rd(`TPC_A_CHBASE, d);
    wr(`TPC_A_CHBASE, 8'h4c);
    rc("clear", `TPC_A_CHBASE, 8'h4c);
    wr(`TPC_A_CHBASE, 8'hcc);
    rc("set none", `TPC_A_CHBASE, 8'h4c);
    // edge pwm, high-true and low-true
    pwmHi(8'h28, 8'h05, h1);
    pwmHi(8'h28, 8'h0a, h2);
    pwmHi(8'h24, 8'h05, h3);
    chk("epwm duty", 16'(h2 - h1), 16'h0096);
    chk("epwm pol", 16'(h1 + h3), 16'h01e0);
    chk("pwm oe", {14'h0, chPinOe}, 16'h0001);
    // compare pin actions: toggle, clear, set
    pwmHi(8'h14, 8'h05, h1);
    chk("oc tgl", 16'(h1), 16'h00f0);
    pwmHi(8'h18, 8'h05, h1);
    chk("oc clr", 16'(h1), 16'h0000);
    pwmHi(8'h1c, 8'h05, h1);
    chk("oc set", 16'(h1), 16'h01e0);
    // software-only compare: flag without pin
    rd(`TPC_A_CHBASE, d);
    pwmHi(8'h10, 8'h05, h1);
    rc("sw cmp", `TPC_A_CHBASE, 8'h90);
    chk("sw oe", {14'h0, chPinOe}, 16'h0000);
    // center-aligned pwm
    wr(`TPC_A_MSC, 8'h68);
    pwmHi(8'h08, 8'h05, h1);
    pwmHi(8'h08, 8'h0a, h2);
    chk("cpwm duty", 16'(h2 - h1), 16'h00a0);
    rc("cpwm flag", `TPC_A_CHBASE, 8'h88);
    end_of_test();
  end
endmodule : timer_pwm_counter_channels_tb
`default_nettype wire
